//--- design/aam_annunciator.sv
// Status lamps, silence toggle and menu session control with Avalon-MM regs
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module aam_annunciator #(
  parameter logic [aam_pkg::TMR_W-1:0] MENU_TO_CYC =
    aam_pkg::TMR_W'(aam_pkg::MENU_TIMEOUT_CYC),
  parameter logic [aam_pkg::TMR_W-1:0] SIL_HOLD_CYC =
    aam_pkg::TMR_W'(aam_pkg::SILENCE_HOLD_CYC),
  parameter logic [aam_pkg::TMR_W-1:0] BLINK_CYC =
    aam_pkg::TMR_W'(aam_pkg::BLINK_HALF_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // Field reports, levels per source
  input wire logic mainsOk,
  input wire logic [aam_pkg::NSRC-1:0] alarmSrc,
  input wire logic [aam_pkg::NSRC-1:0] alarmNonLatch,
  input wire logic [aam_pkg::NSRC-1:0] preSrc,
  input wire logic [aam_pkg::NSRC-1:0] troubleSrc,
  input wire logic [aam_pkg::NSRC-1:0] supvSrc,
  // Keypad and menu requests, one-cycle pulses; atTopMenu and termSession are levels
  input wire logic keyAck,
  input wire logic keySilence,
  input wire logic keyReset,
  input wire logic keyBackspace,
  input wire logic keyAny,
  input wire logic atTopMenu,
  input wire logic localMenuReq,
  input wire logic remoteMenuReq,
  input wire logic termSession,
  // Lamps and outputs
  output logic powerLamp,
  output logic alarmLamp,
  output logic preLamp,
  output logic troubleLamp,
  output logic supvLamp,
  output logic silenceLamp,
  output logic outputsSilenced,
  output logic sounderOn,
  output logic normalMode,
  output logic showCustomLine,
  output logic localGrant,
  output logic remoteGrant,
  output logic remoteRefused,
  output logic localRefused
);
  import aam_pkg::*;

  function automatic logic risingAny(input logic [NSRC-1:0] prev,
                                     input logic [NSRC-1:0] cur);
    risingAny = |(cur & ~prev);
  endfunction

  logic [NSRC-1:0] alarmPrev_q;
  logic [2:0][NSRC-1:0] othSrc;
  logic [2:0][NSRC-1:0] othPrev_q;
  logic [2:0] othUnack_q;
  logic [2:0] othLamp_q;
  logic alarmUnackEv_q, alarmUnackClr_q, alarmLatch_q;
  logic alarmNew, alarmClrRpt, ackNow, allAlarmAcked, resetOk;
  logic [TMR_W-1:0] blinkCnt_q;
  logic blink_q;
  logic [TMR_W-1:0] silHold_q;
  logic silenceOk;
  logic [TMR_W-1:0] idleCnt_q;
  aam_sess_t sess_q;
  logic [1:0] ctrl_q;
  logic swAck_q;
  logic busHit;
  logic [31:0] statusWord;

  assign othSrc = {supvSrc, troubleSrc, preSrc};
  assign ackNow = keyAck | swAck_q;
  // Alarm, silence and reset inputs watched each cycle regardless of mode or session
  assign alarmNew = risingAny(alarmPrev_q, alarmSrc);
  assign alarmClrRpt = |(alarmPrev_q & ~alarmSrc & alarmNonLatch);
  assign allAlarmAcked = !alarmUnackEv_q && !alarmUnackClr_q && !alarmNew;
  assign resetOk = keyReset && allAlarmAcked && !(|alarmSrc);
  assign silenceOk = keySilence && allAlarmAcked && alarmLatch_q &&
                     (silHold_q == '0);

  // Edge history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarmPrev_q <= '0;
      othPrev_q <= '0;
    end else begin
      alarmPrev_q <= alarmSrc;
      othPrev_q <= othSrc;
    end
  end

  // Shared blink generator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blinkCnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blinkCnt_q >= BLINK_CYC - TMR_W'(1)) begin
      blinkCnt_q <= '0;
      blink_q <= ~blink_q;
    end else begin
      blinkCnt_q <= blinkCnt_q + TMR_W'(1);
    end
  end

  // Alarm acknowledge state; new events win over acknowledge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarmUnackEv_q <= 1'b0;
      alarmUnackClr_q <= 1'b0;
      alarmLatch_q <= 1'b0;
    end else begin
      if (alarmNew)
        alarmUnackEv_q <= 1'b1;
      else if (ackNow)
        alarmUnackEv_q <= 1'b0;
      if (alarmClrRpt && alarmLatch_q)
        alarmUnackClr_q <= 1'b1;
      else if (ackNow)
        alarmUnackClr_q <= 1'b0;
      if (alarmNew)
        alarmLatch_q <= 1'b1;
      else if (resetOk)
        alarmLatch_q <= 1'b0;
    end
  end

  // Pre-alarm, trouble and supervisory classes
  for (genvar c = 0; c < 3; c++) begin : g_cls
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        othUnack_q[c] <= 1'b0;
        othLamp_q[c] <= 1'b0;
      end else begin
        if (risingAny(othPrev_q[c], othSrc[c]))
          othUnack_q[c] <= 1'b1;
        else if (ackNow || !(|othSrc[c]))
          othUnack_q[c] <= 1'b0;
        if (!(|othSrc[c]))
          othLamp_q[c] <= 1'b0;
        else
          othLamp_q[c] <= othUnack_q[c] ? blink_q : 1'b1;
      end
    end
  end
  assign preLamp = othLamp_q[0];
  assign troubleLamp = othLamp_q[1];
  assign supvLamp = othLamp_q[2];

  // Power, alarm lamp, sounder and normal display
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      powerLamp <= 1'b0;
      alarmLamp <= 1'b0;
      sounderOn <= 1'b0;
      normalMode <= 1'b0;
      showCustomLine <= 1'b0;
    end else begin
      powerLamp <= mainsOk;
      if (!alarmLatch_q)
        alarmLamp <= 1'b0;
      else if (alarmUnackEv_q || alarmUnackClr_q)
        alarmLamp <= blink_q;
      else
        alarmLamp <= 1'b1;
      sounderOn <= ctrl_q[CTRL_SOUNDER_BIT] &&
                   (alarmUnackEv_q || alarmUnackClr_q || (|othUnack_q));
      normalMode <= !alarmLatch_q && !(|othSrc) && !(|alarmSrc);
      showCustomLine <= !alarmLatch_q && !(|othSrc) && !(|alarmSrc) &&
                        ctrl_q[CTRL_CUSTOM_BIT];
    end
  end

  // Silence toggle and hold-off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outputsSilenced <= 1'b0;
      silenceLamp <= 1'b0;
      silHold_q <= '0;
    end else begin
      if (silenceOk)
        silHold_q <= SIL_HOLD_CYC;
      else if (silHold_q != '0)
        silHold_q <= silHold_q - TMR_W'(1);
      if (resetOk) begin
        outputsSilenced <= 1'b0;
        silenceLamp <= 1'b0;
      end else if (silenceOk) begin
        outputsSilenced <= ~outputsSilenced;
        silenceLamp <= ~outputsSilenced;
      end
    end
  end

  // Menu session arbitration and idle timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sess_q <= SESS_IDLE;
      idleCnt_q <= '0;
      remoteRefused <= 1'b0;
      localRefused <= 1'b0;
    end else begin
      remoteRefused <= remoteMenuReq && (sess_q != SESS_IDLE ||
                       termSession);
      localRefused <= localMenuReq && (sess_q != SESS_IDLE ||
                      termSession);
      unique case (sess_q)
        SESS_IDLE: begin
          idleCnt_q <= '0;
          if (localMenuReq && !termSession && !alarmNew)
            sess_q <= SESS_LOCAL;
          else if (remoteMenuReq && !termSession && !alarmNew)
            sess_q <= SESS_REMOTE;
        end
        SESS_LOCAL, SESS_REMOTE: begin
          if (alarmNew || (keyBackspace && atTopMenu) ||
              idleCnt_q >= MENU_TO_CYC - TMR_W'(1)) begin
            sess_q <= SESS_IDLE;
            idleCnt_q <= '0;
          end else if (keyAny) begin
            idleCnt_q <= '0;
          end else begin
            idleCnt_q <= idleCnt_q + TMR_W'(1);
          end
        end
      endcase
    end
  end
  assign localGrant = sess_q[1];
  assign remoteGrant = sess_q[2];

  // Avalon-MM slave, one wait cycle per access
  assign busHit = (avsRead || avsWrite) && avsWaitrequest;
  assign statusWord = {21'h00_0000, outputsSilenced, alarmLatch_q,
                       alarmUnackEv_q | alarmUnackClr_q, sounderOn,
                       normalMode, silenceLamp, supvLamp, troubleLamp,
                       preLamp, alarmLamp, powerLamp};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avsWaitrequest <= 1'b1;
      avsReaddata <= '0;
      ctrl_q <= CTRL_RESET;
      swAck_q <= 1'b0;
    end else begin
      avsWaitrequest <= !busHit;
      swAck_q <= 1'b0;
      if (busHit && avsRead) begin
        unique case (avsAddress)
          OFS_CTRL: avsReaddata <= {30'h0000_0000, ctrl_q};
          OFS_STATUS: avsReaddata <= statusWord;
          OFS_SESSION: avsReaddata <= {29'h0000_0000, sess_q};
          default: avsReaddata <= '0;
        endcase
      end
      if (busHit && avsWrite && avsAddress == OFS_CTRL && avsByteenable[0])
        begin
        ctrl_q <= avsWritedata[1:0];
        swAck_q <= avsWritedata[CTRL_SWACK_BIT];
      end
    end
  end

  // Checks
  power_lamp_a: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> powerLamp == $past(mainsOk))
    else $error("power lamp does not follow mains");
  alarm_steady_a: assert property (@(posedge clk) disable iff (!resetn)
    (alarmLatch_q && !alarmUnackEv_q && !alarmUnackClr_q) |=> alarmLamp)
    else $error("acknowledged alarm lamp not steady");
  alarm_reset_a: assert property (@(posedge clk) disable iff (!resetn)
    (keyReset && |alarmSrc) |=> alarmLatch_q)
    else $error("alarm cleared while source still active");
  class_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (troubleSrc == '0) |=> !troubleLamp)
    else $error("trouble lamp lit with no source");
  silence_mirror_a: assert property (@(posedge clk) disable iff (!resetn)
    silenceLamp == outputsSilenced)
    else $error("silence lamp differs from outputs state");
  silence_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    silenceOk |=> !silenceOk [*3])
    else $error("silence accepted inside hold-off");
  alarm_ends_a: assert property (@(posedge clk) disable iff (!resetn)
    alarmNew |=> sess_q == SESS_IDLE)
    else $error("session survived alarm");
  remote_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
    (remoteMenuReq && sess_q == SESS_LOCAL) |=> remoteRefused &&
    sess_q != SESS_REMOTE)
    else $error("remote request not refused");
  term_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
    (sess_q == SESS_IDLE && localMenuReq && termSession) |=>
    sess_q == SESS_IDLE)
    else $error("local session granted during terminal session");
  backspace_a: assert property (@(posedge clk) disable iff (!resetn)
    (sess_q != SESS_IDLE && keyBackspace && atTopMenu) |=>
    sess_q == SESS_IDLE && idleCnt_q == '0)
    else $error("backspace at top menu kept session");
  idle_bound_a: assert property (@(posedge clk) disable iff (!resetn)
    idleCnt_q < MENU_TO_CYC)
    else $error("idle counter passed timeout");
  bus_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    !avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule // aam_annunciator

//--- design/aam_pkg.sv
// Constants shared by the annunciator and menu session controller
package aam_pkg;
  // Clock and timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint MENU_TIMEOUT_S = 60;
  localparam longint SILENCE_HOLD_S = 10;
  localparam longint BLINK_HALF_MS = 500;
  localparam longint MENU_TIMEOUT_CYC = MENU_TIMEOUT_S * CLK_HZ;
  localparam longint SILENCE_HOLD_CYC = SILENCE_HOLD_S * CLK_HZ;
  localparam longint BLINK_HALF_CYC = (BLINK_HALF_MS * CLK_HZ) / 1000;
  localparam int TMR_W = 33;
  // Sources per event class
  localparam int NSRC = 8;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_SESSION = 4'h8;
  // Control fields
  localparam int CTRL_CUSTOM_BIT = 0;
  localparam int CTRL_SOUNDER_BIT = 1;
  localparam int CTRL_SWACK_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  // Status fields
  localparam int ST_POWER = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_PRE = 2;
  localparam int ST_TRBL = 3;
  localparam int ST_SUPV = 4;
  localparam int ST_SILENCE = 5;
  localparam int ST_NORMAL = 6;
  localparam int ST_SOUNDER = 7;
  localparam int ST_ALM_UNACK = 8;
  localparam int ST_ALM_LATCH = 9;
  localparam int ST_OUTS_OFF = 10;
  // Menu session states, one-hot
  typedef enum logic [2:0] {
    SESS_IDLE = 3'b001,
    SESS_LOCAL = 3'b010,
    SESS_REMOTE = 3'b100
  } aam_sess_t;
endpackage

//--- sim/aam_panel_model.sv
// Keypad, menu requesters and field sources facing the annunciator
`timescale 1ns/10ps
module aam_panel_model (
  // Clock
  input wire logic clk,
  // Keypad and menu requests
  output logic keyAck,
  output logic keySilence,
  output logic keyReset,
  output logic keyBackspace,
  output logic keyAny,
  output logic atTopMenu,
  output logic localMenuReq,
  output logic remoteMenuReq,
  output logic termSession,
  // Field reports
  output logic mainsOk,
  output logic [7:0] alarmSrc,
  output logic [7:0] alarmNonLatch,
  output logic [7:0] preSrc,
  output logic [7:0] troubleSrc,
  output logic [7:0] supvSrc
);
  initial begin
    {keyAck, keySilence, keyReset, keyBackspace, keyAny} = 5'h00;
    {localMenuReq, remoteMenuReq, termSession} = 3'h0;
    atTopMenu = 1'b1;
    mainsOk = 1'b1;
    {alarmSrc, alarmNonLatch, preSrc, troubleSrc, supvSrc} = '0;
  end
  // Codes: 0 ack 1 silence 2 reset 3 backspace 4 local 5 remote 6 other
  task automatic press(input int k);
    @(posedge clk);
    keyAck <= (k == 0);
    keySilence <= (k == 1);
    keyReset <= (k == 2);
    keyBackspace <= (k == 3);
    localMenuReq <= (k == 4);
    remoteMenuReq <= (k == 5);
    // Remote display requests are not local key presses
    keyAny <= (k != 5);
    @(posedge clk);
    {keyAck, keySilence, keyReset, keyBackspace, keyAny} <= 5'h00;
    {localMenuReq, remoteMenuReq} <= 2'h0;
  endtask
endmodule // aam_panel_model

//--- sim/test_aam_annunciator.sv
// Self-checking bench for the annunciator and menu session controller
`timescale 1ns/10ps
module test_aam_annunciator;
  import aam_pkg::*;
  logic clk, resetn, avsRead, avsWrite, avsWaitrequest;
  logic [3:0] avsAddress, avsByteenable;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic keyAck, keySilence, keyReset, keyBackspace, keyAny, atTopMenu;
  logic localMenuReq, remoteMenuReq, termSession, mainsOk;
  logic [NSRC-1:0] alarmSrc, alarmNonLatch, preSrc, troubleSrc, supvSrc;
  logic powerLamp, alarmLamp, preLamp, troubleLamp, supvLamp, silenceLamp;
  logic outputsSilenced, sounderOn, normalMode, showCustomLine;
  logic localGrant, remoteGrant, remoteRefused, localRefused;
  logic [3:0] lamps;
  int n_errors = 0;
  int num_checks = 0;
  assign lamps = {supvLamp, troubleLamp, preLamp, alarmLamp};
  aam_panel_model i_pan (.clk, .keyAck, .keySilence, .keyReset,
    .keyBackspace, .keyAny, .atTopMenu, .localMenuReq, .remoteMenuReq,
    .termSession, .mainsOk, .alarmSrc, .alarmNonLatch, .preSrc,
    .troubleSrc, .supvSrc);
  aam_annunciator #(.MENU_TO_CYC(50), .SIL_HOLD_CYC(8), .BLINK_CYC(2))
  i_dut (.clk, .resetn, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsByteenable, .avsReaddata, .avsWaitrequest, .mainsOk, .alarmSrc,
    .alarmNonLatch, .preSrc, .troubleSrc, .supvSrc, .keyAck, .keySilence,
    .keyReset, .keyBackspace, .keyAny, .atTopMenu, .localMenuReq,
    .remoteMenuReq, .termSession, .powerLamp, .alarmLamp, .preLamp,
    .troubleLamp, .supvLamp, .silenceLamp, .outputsSilenced, .sounderOn,
    .normalMode, .showCustomLine, .localGrant, .remoteGrant,
    .remoteRefused, .localRefused);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic bus(input bit wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsRead <= !wr;
    avsWrite <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    if (avsWaitrequest !== 1'b0) begin
      n_errors++;
      $display("MISMATCH %0t bus timeout", $time);
      stop_test();
    end
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Mode over eight cycles: 0 off, 1 steady, 2 flashing
  task automatic lamp(input int b, input int mode, input string m);
    int ones;
    ones = 0;
    repeat (8) begin
      @(negedge clk);
      ones += (lamps[b] === 1'b1);
    end
    chk((ones == 0) ? 0 : (ones == 8) ? 1 : 2, mode, m);
  endtask
  task automatic t_regs();
    idle(2);
    chk({powerLamp, normalMode, showCustomLine}, 3'h7, "idle lamps");
    i_pan.mainsOk <= 1'b0;
    idle(2);
    chk(powerLamp, 1'b0, "power lamp lit");
    i_pan.mainsOk <= 1'b1;
    bus(0, OFS_CTRL, 0);
    chk(rd, 32'h0000_0003, "ctrl reset");
    bus(1, OFS_CTRL, 0);
    idle(1);
    chk(showCustomLine, 1'b0, "custom line");
    bus(1, 4'hc, 32'h0000_0003);
    bus(0, 4'hc, 0);
    chk(rd, 0, "unmapped read");
    bus(0, OFS_CTRL, 0);
    chk(rd, 0, "unmapped write");
    bus(1, OFS_CTRL, 32'h0000_0003);
    avsByteenable <= 4'h0;
    bus(1, OFS_CTRL, 0);
    avsByteenable <= 4'hf;
    bus(0, OFS_CTRL, 0);
    chk(rd, 32'h0000_0003, "masked write landed");
    bus(0, OFS_SESSION, 0);
    chk(rd, 32'h0000_0001, "session idle");
    $display("t_regs done");
  endtask
  task automatic t_alarm();
    i_pan.press(4);
    i_pan.alarmSrc <= 8'h01;
    idle(2);
    chk({localGrant, sounderOn}, 2'h1, "alarm vs session");
    lamp(0, 2, "alarm flash");
    i_pan.press(0);
    idle(2);
    chk(sounderOn, 1'b0, "sounder after ack");
    lamp(0, 1, "alarm steady");
    i_pan.press(1);
    idle(1);
    chk({silenceLamp, outputsSilenced}, 2'h3, "silence on");
    i_pan.press(1);
    idle(1);
    chk(silenceLamp, 1'b1, "silence hold-off");
    idle(10);
    i_pan.press(1);
    idle(1);
    chk({silenceLamp, outputsSilenced}, 2'h0, "silence off");
    idle(10);
    i_pan.press(1);
    i_pan.press(2);
    idle(2);
    chk({alarmLamp, silenceLamp}, 2'h3, "reset refused");
    i_pan.alarmNonLatch <= 8'h01;
    i_pan.alarmSrc <= 8'h00;
    idle(2);
    lamp(0, 2, "cleared report flash");
    i_pan.press(0);
    idle(2);
    lamp(0, 1, "cleared report steady");
    i_pan.press(2);
    idle(2);
    chk({alarmLamp, silenceLamp, normalMode}, 3'h1, "reset");
    $display("t_alarm done");
  endtask
  task automatic t_class(input int c);
    i_pan.preSrc <= {7'h00, c == 1};
    i_pan.troubleSrc <= {7'h00, c == 2};
    i_pan.supvSrc <= {7'h00, c == 3};
    idle(2);
    chk(normalMode, 1'b0, "normal with event");
    lamp(c, 2, "class flash");
    i_pan.press(0);
    idle(2);
    lamp(c, 1, "class steady");
    {i_pan.preSrc, i_pan.troubleSrc, i_pan.supvSrc} <= '0;
    idle(2);
    lamp(c, 0, "class off");
    $display("t_class %0d done", c);
  endtask
  task automatic t_menu();
    i_pan.press(4);
    @(negedge clk);
    chk(localGrant, 1'b1, "local grant");
    i_pan.press(5);
    @(negedge clk);
    chk({remoteRefused, remoteGrant}, 2'h2, "remote refused");
    i_pan.atTopMenu <= 1'b0;
    i_pan.press(3);
    @(negedge clk);
    chk(localGrant, 1'b1, "backspace in submenu");
    i_pan.atTopMenu <= 1'b1;
    i_pan.press(3);
    @(negedge clk);
    chk(localGrant, 1'b0, "backspace exit");
    i_pan.termSession <= 1'b1;
    i_pan.press(4);
    @(negedge clk);
    chk({localRefused, localGrant}, 2'h2, "terminal held");
    i_pan.termSession <= 1'b0;
    i_pan.press(4);
    idle(30);
    i_pan.press(6);
    idle(40);
    chk(localGrant, 1'b1, "key restarts timer");
    idle(20);
    chk(localGrant, 1'b0, "idle timeout");
    $display("t_menu done");
  endtask
  initial begin
    resetn = 1'b0;
    {avsRead, avsWrite, avsAddress, avsWritedata} = '0;
    avsByteenable = 4'hf;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_alarm();
    for (int c = 1; c < 4; c++) t_class(c);
    t_menu();
    stop_test();
  end
endmodule // test_aam_annunciator
